// file: design/pld_pkg.sv
// package for the dpll phase lock and loss detector
package pld_pkg;

  // register selects on the configuration port
  localparam logic [0:0] SEL_FINE         = 1'h0;
  localparam logic [0:0] SEL_COARSE       = 1'h1;

  // reset values
  localparam logic [7:0] FINE_RESET       = 8'ha2;
  localparam logic [7:0] COARSE_RESET     = 8'he5;

  // fine config field positions
  localparam int         FINE_EN_BIT      = 7;
  localparam int         INACT_LOSS_BIT   = 6;
  localparam int         NARROW_EN_BIT    = 5;
  localparam int         FINE_LIM_LSB     = 0;
  localparam int         FINE_LIM_W       = 3;
  localparam logic [7:0] FINE_WMASK       = 8'he7;

  // coarse config field positions
  localparam int         COARSE_EN_BIT    = 7;
  localparam int         WIDE_RANGE_BIT   = 6;
  localparam int         MULTI_RESP_BIT   = 5;
  localparam int         COARSE_LIM_LSB   = 0;
  localparam int         COARSE_LIM_W     = 4;
  localparam logic [7:0] COARSE_WMASK     = 8'hef;

  // phase error magnitude is in 1/256 of a cycle; one limit step is 45 degrees
  localparam int         PH_W             = 8;
  localparam logic [7:0] FINE_STEP        = 8'h20;

  // lock qualification time, lower end of the documented span
  localparam int         CLK_MHZ          = 100;
  localparam int         LOCK_QUAL_MS     = 1000;
  localparam int         LOCK_QUAL_CYC    = LOCK_QUAL_MS * 1000 * CLK_MHZ;
  localparam int         QUAL_CNT_W       = 27;

  typedef enum logic [1:0] {
    PLD_ACQUIRE,
    PLD_QUALIFY,
    PLD_LOCKED
  } pld_state_e;

  // write request from the serial register port logic
  typedef struct packed {
    logic       wr;
    logic [0:0] sel;
    logic [7:0] data;
  } pld_reg_req_s;

  // configuration handed to the dpll core
  typedef struct packed {
    logic       coarse_en;
    logic       wide_range_en;
    logic       multi_cycle_response;
    logic [3:0] coarse_limit;
  } pld_core_cfg_s;

  typedef struct packed {
    logic phase_lock;
    logic phase_loss;
    logic full_acquire;
  } pld_status_s;

endpackage : pld_pkg

// file: design/pld_detector.sv
// phase lock and phase loss detection for the dpll reference input
`timescale 1ns/1ps
// Functional notes
// RQ1 - With fine checking enabled, phase loss is raised when the phase error exceeds the fine limit.
// RQ2 - With fine checking disabled, only the other loss sources can raise phase loss.
// RQ3 - Lock is shown only after the phase stays inside the fine window for the qualify time.
// RQ4 - Leaving the fine window raises phase loss at once with no qualification.
// RQ5 - Limit code 010 gives a window of about plus or minus 90 to 180 degrees and is the default.
// RQ6 - The window scales with the limit code and software must not program code 000.
// RQ7 - With the inactivity bit clear, lost activity is not loss and the loop relocks nearest-edge.
// RQ8 - After phase loss the loop runs full frequency and phase acquisition over 360 degrees.
// RQ9 - Software keeps the test-only narrow enable bit at one.
module pld_detector #(
  parameter int LOCK_QUAL_CYC = pld_pkg::LOCK_QUAL_CYC
) (
  // clock, reset, enable
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   clk_en,
  // register port from the serial interface logic
  input  wire pld_pkg::pld_reg_req_s  reg_req,
  input  wire logic [0:0]             rd_sel,
  output logic [7:0]                  rd_data,
  // measurements from the dpll core and activity monitor
  input  wire logic [pld_pkg::PH_W-1:0] phase_err_mag,
  input  wire logic                   ref_active,
  input  wire logic                   coarse_loss,
  // results
  output pld_pkg::pld_status_s        status,
  output pld_pkg::pld_core_cfg_s      core_cfg
);

  logic [7:0]                     fine_config;
  logic [7:0]                     coarse_config;
  logic [7:0]                     next_fine_config;
  logic [7:0]                     next_coarse_config;
  pld_pkg::pld_state_e            state;
  pld_pkg::pld_state_e            next_state;
  logic [pld_pkg::QUAL_CNT_W-1:0] qual_cnt;
  logic [pld_pkg::QUAL_CNT_W-1:0] next_qual_cnt;
  pld_pkg::pld_status_s           next_status;
  logic [7:0]                     next_rd_data;
  logic [pld_pkg::PH_W:0]         win_limit;
  logic                           outside_fine;
  logic                           fine_loss;
  logic                           inact_loss;
  logic                           loss_now;

  // register file; unused bits [4:3] of fine and bit 4 of coarse read as zero
  always_comb begin
    next_fine_config   = fine_config;
    next_coarse_config = coarse_config;
    if (reg_req.wr) begin
      if (reg_req.sel == pld_pkg::SEL_FINE) begin
        next_fine_config = reg_req.data & pld_pkg::FINE_WMASK;
      end else begin
        next_coarse_config = reg_req.data & pld_pkg::COARSE_WMASK;
      end
    end
    next_rd_data = (rd_sel == pld_pkg::SEL_FINE) ? next_fine_config : next_coarse_config;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      fine_config   <= pld_pkg::FINE_RESET; // RQ5 RQ9
      coarse_config <= pld_pkg::COARSE_RESET;
      rd_data       <= pld_pkg::FINE_RESET;
    end else if (clk_en) begin
      fine_config   <= next_fine_config;
      coarse_config <= next_coarse_config;
      rd_data       <= next_rd_data;
    end
  end

  // window half-width grows linearly with the code; code 000 gives a zero window,
  // so any nonzero error counts as outside and lock qualifies only while the error stays zero
  assign win_limit    = (pld_pkg::PH_W+1)'(fine_config[pld_pkg::FINE_LIM_LSB +:
                        pld_pkg::FINE_LIM_W]) * {1'h0, pld_pkg::FINE_STEP}; // RQ5 RQ6
  assign outside_fine = {1'h0, phase_err_mag} > win_limit;
  assign fine_loss    = fine_config[pld_pkg::FINE_EN_BIT] & outside_fine; // RQ1 RQ2
  assign inact_loss   = fine_config[pld_pkg::INACT_LOSS_BIT] & ~ref_active; // RQ7
  assign loss_now     = fine_loss | coarse_loss | inact_loss; // RQ2 RQ4

  // lock qualification and acquisition mode
  always_comb begin
    next_state    = state;
    next_qual_cnt = qual_cnt;
    case (state)
      pld_pkg::PLD_ACQUIRE: begin
        next_qual_cnt = '0;
        if (!loss_now && !outside_fine && ref_active) begin
          next_state = pld_pkg::PLD_QUALIFY;
        end
      end
      pld_pkg::PLD_QUALIFY: begin
        if (loss_now) begin
          next_state = pld_pkg::PLD_ACQUIRE; // RQ8
        end else if (outside_fine) begin
          next_qual_cnt = '0; // RQ3
        end else if (ref_active) begin
          // with the inactivity bit clear, a dead reference pauses the count rather than restarting it
          if (qual_cnt >= pld_pkg::QUAL_CNT_W'(LOCK_QUAL_CYC - 1)) begin
            next_state = pld_pkg::PLD_LOCKED; // RQ3
          end else begin
            next_qual_cnt = qual_cnt + 1'b1;
          end
        end
      end
      pld_pkg::PLD_LOCKED: begin
        if (loss_now) begin
          next_state = pld_pkg::PLD_ACQUIRE; // RQ4 RQ8
        end else if (outside_fine) begin
          next_state    = pld_pkg::PLD_QUALIFY;
          next_qual_cnt = '0;
        end
      end
      default: begin
        next_state    = pld_pkg::PLD_ACQUIRE;
        next_qual_cnt = '0;
      end
    endcase
    next_status.phase_loss   = loss_now; // RQ4
    next_status.phase_lock   = (next_state == pld_pkg::PLD_LOCKED); // RQ3
    // outside acquisition the core relocks to the nearest edge, tolerating missed cycles
    next_status.full_acquire = (next_state == pld_pkg::PLD_ACQUIRE); // RQ7 RQ8
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state    <= pld_pkg::PLD_ACQUIRE;
      qual_cnt <= '0;
      status   <= '{phase_lock: 1'b0, phase_loss: 1'b0, full_acquire: 1'b1};
    end else if (clk_en) begin
      state    <= next_state;
      qual_cnt <= next_qual_cnt;
      status   <= next_status;
    end
  end

  assign core_cfg.coarse_en            = coarse_config[pld_pkg::COARSE_EN_BIT];
  assign core_cfg.wide_range_en        = coarse_config[pld_pkg::WIDE_RANGE_BIT];
  assign core_cfg.multi_cycle_response = coarse_config[pld_pkg::MULTI_RESP_BIT];
  assign core_cfg.coarse_limit         = coarse_config[pld_pkg::COARSE_LIM_LSB +:
                                         pld_pkg::COARSE_LIM_W];

endmodule : pld_detector

// file: bench/pld_properties.sv
// port checker for the phase lock and loss detector
`timescale 1ns/1ps
module pld_properties #(parameter int LOCK_QUAL_CYC = 16) (
  // clock and control
  input wire logic core_clk, rst, clk_en,
  input wire pld_pkg::pld_reg_req_s reg_req,
  input wire logic [0:0] rd_sel,
  input wire logic [7:0] rd_data, phase_err_mag,
  input wire logic ref_active, coarse_loss,
  // results
  input wire pld_pkg::pld_status_s status,
  input wire pld_pkg::pld_core_cfg_s core_cfg
);
  int qcnt;
  // lenient count: a fine-disabled requalify keeps counting, never too short
  always_ff @(posedge core_clk or posedge rst)
    if (rst) qcnt <= 0;
    else if (clk_en) qcnt <= (status.phase_loss || status.full_acquire) ? 0 : qcnt + 1;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  AST_COARSE: assert property (clk_en && coarse_loss |=> status.phase_loss)
    else $error("coarse loss not shown");
  AST_CLEAR: assert property (clk_en && !coarse_loss && ref_active && phase_err_mag == 8'h00
    |=> !status.phase_loss) else $error("loss with zero error");
  AST_ACQ: assert property (status.phase_loss |-> status.full_acquire)
    else $error("loss without full acquisition");
  AST_EXCL: assert property (status.phase_loss |-> !status.phase_lock)
    else $error("lock and loss together");
  AST_QUAL: assert property ($rose(status.phase_lock) |-> qcnt >= LOCK_QUAL_CYC - 1)
    else $error("lock too early");
  AST_FREEZE: assert property (!clk_en |=> $stable(status))
    else $error("status moved while disabled");
  AST_WR: assert property (clk_en && reg_req.wr && reg_req.sel == rd_sel |=> rd_data ==
    ($past(reg_req.data) & ($past(rd_sel) ? pld_pkg::COARSE_WMASK : pld_pkg::FINE_WMASK)))
    else $error("read after write wrong");
  AST_CFG: assert property (clk_en && reg_req.wr && reg_req.sel == pld_pkg::SEL_COARSE
    |=> core_cfg == {$past(reg_req.data[7:5]), $past(reg_req.data[3:0])})
    else $error("core cfg not from coarse");
endmodule : pld_properties
bind pld_detector pld_properties #(.LOCK_QUAL_CYC(LOCK_QUAL_CYC)) u_props (.core_clk, .rst,
  .clk_en, .reg_req, .rd_sel, .rd_data, .phase_err_mag, .ref_active, .coarse_loss, .status,
  .core_cfg);

// file: bench/pld_ref_model.sv
// reference input model: measured phase error and activity
`timescale 1ns/1ps
module pld_ref_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] err_cmd,
  input  wire logic       active_cmd,
  output logic      [7:0] phase_err_mag,
  output logic            ref_active
);
  logic [7:0] last = 8'h00;
  // no edges means nothing new to measure, so the last error holds
  always @(posedge core_clk) if (active_cmd) last <= err_cmd;
  assign phase_err_mag = active_cmd ? err_cmd : last;
  assign ref_active    = active_cmd;
endmodule : pld_ref_model

// file: bench/tb.sv
// self-checking bench for the phase lock and loss detector
`timescale 1ns/1ps
module tb;
  localparam int Q = 16;
  logic core_clk = 1'b0, rst = 1'b1, clk_en = 1'b1, coarse_loss = 1'b0, act = 1'b1, ref_active;
  logic [0:0] rd_sel = 1'h0;
  logic [7:0] err = 8'h00, rd_data, mag;
  pld_pkg::pld_reg_req_s  req = '0;
  pld_pkg::pld_status_s   st;
  pld_pkg::pld_core_cfg_s cfg;
  int err_total = 0, n_tests = 0, cyc = 0, n;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total = err_total + 1;
      summarize();
    end
  end
  pld_ref_model u_ref (.core_clk, .err_cmd(err), .active_cmd(act), .phase_err_mag(mag),
    .ref_active);
  pld_detector #(.LOCK_QUAL_CYC(Q)) u_dut (.core_clk, .rst, .clk_en, .reg_req(req), .rd_sel,
    .rd_data, .phase_err_mag(mag), .ref_active, .coarse_loss, .status(st), .core_cfg(cfg));
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("Error %0t %s", $time, m);
    end
  endtask : chk
  task automatic wr(input logic [0:0] s, input logic [7:0] d);
    @(negedge core_clk) req = '{wr: 1'b1, sel: s, data: d};
    @(negedge core_clk) req.wr = 1'b0;
  endtask : wr
  task automatic step(input int k);
    repeat (k) @(negedge core_clk);
  endtask : step
  task automatic t_regs;
    chk(rd_data === pld_pkg::FINE_RESET && st === 3'b001, "reset state");
    chk(cfg === {pld_pkg::COARSE_RESET[7:5], pld_pkg::COARSE_RESET[3:0]}, "reset cfg");
    rd_sel = 1'h1;
    step(1);
    chk(rd_data === pld_pkg::COARSE_RESET, "coarse reset");
    rd_sel = 1'h0;
    wr(1'h0, 8'hff);
    chk(rd_data === 8'he7, "fine mask");
    rd_sel = 1'h1;
    wr(1'h1, 8'hff);
    chk(rd_data === 8'hef && cfg === 7'h7f, "coarse mask");
    wr(1'h1, pld_pkg::COARSE_RESET);
    wr(1'h0, pld_pkg::FINE_RESET);
  endtask : t_regs
  task automatic t_lock;
    err = 8'h10;
    coarse_loss = 1'b1;
    step(2);
    coarse_loss = 1'b0;
    for (n = 0; n < 40 && st.phase_lock !== 1'b1; n++) step(1);
    // one edge to leave acquisition, then the full qualify count
    chk(n == Q + 1 && st.full_acquire === 1'b0, "lock timing");
  endtask : t_lock
  task automatic t_win;
    for (int c = 1; c < 8; c++) begin
      wr(1'h0, {5'b10100, c[2:0]});
      err = 8'(c * 32);
      step(2);
      chk(st.phase_loss === 1'b0, "loss on window edge");
      err = 8'(c * 32 + 1);
      step(1);
      chk(st === 3'b011, "outside not lost at once");
      err = 8'h00;
    end
  endtask : t_win
  task automatic t_off;
    wr(1'h0, 8'h22);
    err = 8'hff;
    step(2);
    chk(st.phase_loss === 1'b0, "fine off still lost");
    coarse_loss = 1'b1;
    step(1);
    chk(st.phase_loss === 1'b1, "coarse loss ignored");
    coarse_loss = 1'b0;
    err = 8'h00;
    wr(1'h0, pld_pkg::FINE_RESET);
    step(3);
  endtask : t_off
  task automatic t_inact;
    act = 1'b0;
    step(3);
    chk(st.phase_loss === 1'b0 && st.full_acquire === 1'b0, "inactivity lost");
    clk_en = 1'b0;
    step(2);
    chk(st === 3'b000 && rd_data === pld_pkg::COARSE_RESET, "moved while disabled");
    clk_en = 1'b1;
    wr(1'h0, 8'he2);
    step(1);
    chk(st.phase_loss === 1'b1 && st.full_acquire === 1'b1, "inactivity kept");
    act = 1'b1;
  endtask : t_inact
  task automatic t_rst;
    rst = 1'b1;
    step(2);
    chk(st === 3'b001 && rd_data === pld_pkg::FINE_RESET && cfg === 7'h75, "mid reset");
    rst = 1'b0;
    step(1);
    chk(st === 3'b000 && rd_data === pld_pkg::COARSE_RESET, "after mid reset");
  endtask : t_rst
  task automatic summarize;
    if (err_total == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (12) @(posedge core_clk);
    @(negedge core_clk) rst = 1'b0;
    t_regs();
    t_lock();
    t_win();
    t_off();
    t_inact();
    t_rst();
    summarize();
  end
endmodule : tb
